// ### hdl/incr_alu.v
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// increment arithmetic and flags
// ****************************************
module incr_alu (
    input  wire [7:0] operand_i,
    output wire [7:0] result_o,
    output wire       carry_o,
    output wire       nibble_borrow_out_o,
    output wire       zero_o,
    output wire       twos_complement_error_o,
    output wire       negative_o
);

    wire [8:0] sum;
    wire [4:0] low_sum;

    assign sum                     = {1'b0, operand_i} + 9'h001;
    assign low_sum                 = {1'b0, operand_i[3:0]} + 5'h01;
    assign result_o                = sum[7:0];
    assign carry_o                 = sum[8];
    assign nibble_borrow_out_o     = low_sum[4];
    assign zero_o                  = (sum[7:0] == 8'h00);
    // only 7f plus one crosses the sign boundary
    assign twos_complement_error_o = ~operand_i[7] & sum[7];
    assign negative_o              = sum[7];

endmodule

`default_nettype wire

// ### hdl/jump_and_increment_exec.v
`timescale 1ns/1ps
`default_nettype none
`include "jump_incr_map.vh"

// Notes on behaviour
// - jump loads its 20-bit literal into program counter bits 20 to 1.
// - jump reaches any address in the whole program space, no restriction.
// - jump is two words: ef plus low byte, then f plus high 12 bits.
// - jump takes two cycles; program counter written in last phase.
// - increment opcode 0010 10da ffff ffff adds one in one cycle.
// - destination bit 0 sends the result to the accumulator only.
// - destination bit 1 writes the result back to the register.
// - bank bit 0 uses access bank; bank bit 1 uses bank pointer.
// - bank bit 0, extended set on, address up to 5f uses indexing.
// - increment updates all five flags; jump leaves flags alone.
module jump_and_increment_exec (
    input  wire        clk_sys_i,
    input  wire        rst_b_i,
    input  wire [5:0]  avs_address_i,
    input  wire        avs_read_i,
    input  wire        avs_write_i,
    input  wire [31:0] avs_writedata_i,
    input  wire [3:0]  avs_byteenable_i,
    output reg  [31:0] avs_readdata_o,
    output wire        avs_waitrequest_o
);

    // ****************************************
    // states
    // ****************************************
    localparam [1:0] ST_IDLE  = 2'b00;
    localparam [1:0] ST_EXEC  = 2'b01;
    localparam [1:0] ST_WORD2 = 2'b10;
    localparam [1:0] ST_NOP   = 2'b11;

    localparam [1:0] PH_Q1 = 2'b00;
    localparam [1:0] PH_Q2 = 2'b01;
    localparam [1:0] PH_Q3 = 2'b10;
    localparam [1:0] PH_Q4 = 2'b11;

    // ****************************************
    // state
    // ****************************************
    reg  [1:0]  state;
    reg  [1:0]  phase;
    reg  [15:0] ireg;
    reg  [7:0]  jump_low;
    reg         is_jump;
    reg         is_incr;
    reg  [11:0] eff_addr;
    reg  [7:0]  operand;
    reg  [7:0]  result;
    reg  [4:0]  next_flags;
    reg  [20:0] program_counter;
    reg  [7:0]  accumulator;
    reg  [4:0]  flags;
    reg  [3:0]  bank_pointer;
    reg  [11:0] index_base;
    reg  [11:0] mem_addr;
    reg         ext_enable;
    reg         bad_word2;
    reg         bad_opcode;
    reg         rd_done;
    reg  [7:0]  data_mem [0:4095];

    wire [7:0]  alu_result;
    wire        alu_c;
    wire        alu_nibble;
    wire        alu_z;
    wire        alu_tcerr;
    wire        alu_n;
    wire        busy;
    wire        word2_wait;
    wire        instr_ofs;
    wire        wr_stall;
    wire        wr_fire;
    wire [31:0] wmask;
    wire [31:0] status_word;
    wire        incr_write_mem;
    wire [15:0] instr_in;
    wire [31:0] wr_old;
    wire [31:0] wr_merged;

    // ****************************************
    // bus handshake
    // ****************************************
    assign busy       = (state != ST_IDLE);
    assign word2_wait = (state == ST_WORD2);
    assign instr_ofs  = (avs_address_i == `JI_OFS_INSTR);
    // writes wait while a cycle runs, except the awaited second word
    assign wr_stall   = avs_write_i & busy & ~(word2_wait & instr_ofs);
    assign wr_fire    = avs_write_i & ~wr_stall;
    assign avs_waitrequest_o = (avs_read_i & ~rd_done) | wr_stall;
    assign instr_in   = avs_writedata_i[15:0];

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_lane
            assign wmask[8*gi+7:8*gi] = {8{avs_byteenable_i[gi]}};
        end
    endgenerate

    function [31:0] merge;
        input [31:0] old_val;
        input [31:0] new_val;
        input [31:0] mask;
        begin
            merge = (old_val & ~mask) | (new_val & mask);
        end
    endfunction

    // current value of the addressed register, for byte-lane merging
    assign wr_old =
        (avs_address_i == `JI_OFS_STATUS)   ? {27'h0, flags} :
        (avs_address_i == `JI_OFS_PROG)     ? {11'h0, program_counter} :
        (avs_address_i == `JI_OFS_ACC)      ? {24'h0, accumulator} :
        (avs_address_i == `JI_OFS_BANK)     ? {28'h0, bank_pointer} :
        (avs_address_i == `JI_OFS_INDEX)    ? {20'h0, index_base} :
        (avs_address_i == `JI_OFS_MEM_ADDR) ? {20'h0, mem_addr} :
                                              32'h00000000;
    assign wr_merged = merge(wr_old, avs_writedata_i, wmask);

    // ****************************************
    // effective data address
    // ****************************************
    function [11:0] data_address;
        input [7:0]  f;
        input        a;
        input        ext;
        input [3:0]  bank;
        input [11:0] base;
        begin
            if (a) begin
                data_address = {bank, f};
            end else if (ext && (f <= `JI_IDX_LIMIT)) begin
                data_address = base + {4'h0, f};
            end else if (f < `JI_ACCESS_SPLIT) begin
                data_address = {`JI_ACCESS_LOW, f};
            end else begin
                data_address = {`JI_ACCESS_HIGH, f};
            end
        end
    endfunction

    // ****************************************
    // arithmetic
    // ****************************************
    incr_alu u_alu (
        .operand_i               (operand),
        .result_o                (alu_result),
        .carry_o                 (alu_c),
        .nibble_borrow_out_o     (alu_nibble),
        .zero_o                  (alu_z),
        .twos_complement_error_o (alu_tcerr),
        .negative_o              (alu_n)
    );

    // ****************************************
    // status word
    // ****************************************
    assign status_word = {20'h00000, bad_opcode, bad_word2, word2_wait,
                          busy, 3'b000, flags};

    // ****************************************
    // data memory
    // ****************************************
    assign incr_write_mem = (state == ST_EXEC) && (phase == PH_Q4) &&
                            is_incr && ireg[9];

    always @(posedge clk_sys_i) begin
        if (incr_write_mem) begin
            data_mem[eff_addr] <= result;
        end else if (wr_fire && avs_byteenable_i[0] &&
                     (avs_address_i == `JI_OFS_MEM_DATA)) begin
            data_mem[mem_addr] <= avs_writedata_i[7:0];
        end
    end

    // ****************************************
    // read path
    // ****************************************
    always @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rd_done        <= 1'b0;
            avs_readdata_o <= 32'h00000000;
        end else begin
            rd_done <= avs_read_i & ~rd_done;
            if (avs_read_i && !rd_done) begin
                case (avs_address_i)
                    `JI_OFS_CTRL:     avs_readdata_o <= {31'h0, ext_enable};
                    `JI_OFS_STATUS:   avs_readdata_o <= status_word;
                    `JI_OFS_PROG:     avs_readdata_o <= {11'h0, program_counter};
                    `JI_OFS_ACC:      avs_readdata_o <= {24'h0, accumulator};
                    `JI_OFS_BANK:     avs_readdata_o <= {28'h0, bank_pointer};
                    `JI_OFS_INDEX:    avs_readdata_o <= {20'h0, index_base};
                    `JI_OFS_MEM_ADDR: avs_readdata_o <= {20'h0, mem_addr};
                    `JI_OFS_MEM_DATA: avs_readdata_o <= {24'h0,
                                                         data_mem[mem_addr]};
                    default:          avs_readdata_o <= 32'h00000000;
                endcase
            end
        end
    end

    // ****************************************
    // sequencer and core registers
    // ****************************************
    always @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state           <= ST_IDLE;
            phase           <= PH_Q1;
            ireg            <= 16'h0000;
            jump_low        <= `JI_RST_BYTE;
            is_jump         <= 1'b0;
            is_incr         <= 1'b0;
            eff_addr        <= `JI_RST_ADDR;
            operand         <= `JI_RST_BYTE;
            result          <= `JI_RST_BYTE;
            next_flags      <= `JI_RST_FLAGS;
            program_counter <= `JI_RST_PROG;
            accumulator     <= `JI_RST_BYTE;
            flags           <= `JI_RST_FLAGS;
            bank_pointer    <= `JI_RST_BANK;
            index_base      <= `JI_RST_ADDR;
            mem_addr        <= `JI_RST_ADDR;
            ext_enable      <= 1'b0;
            bad_word2       <= 1'b0;
            bad_opcode      <= 1'b0;
        end else begin
            // software side, only while idle except the second word
            if (wr_fire && !busy) begin
                case (avs_address_i)
                    `JI_OFS_INSTR: begin
                        ireg  <= instr_in;
                        state <= ST_EXEC;
                        phase <= PH_Q1;
                    end
                    `JI_OFS_CTRL: begin
                        if (avs_byteenable_i[0]) begin
                            ext_enable <= avs_writedata_i[`JI_CTRL_EXT_BIT];
                        end
                    end
                    `JI_OFS_STATUS: begin
                        flags <= wr_merged[4:0];
                        if (avs_byteenable_i[1] &&
                            avs_writedata_i[`JI_ST_BADW2_BIT]) begin
                            bad_word2 <= 1'b0;
                        end
                        if (avs_byteenable_i[1] &&
                            avs_writedata_i[`JI_ST_BADOP_BIT]) begin
                            bad_opcode <= 1'b0;
                        end
                    end
                    `JI_OFS_PROG: begin
                        program_counter <= {wr_merged[20:1], 1'b0};
                    end
                    `JI_OFS_ACC: begin
                        accumulator <= wr_merged[7:0];
                    end
                    `JI_OFS_BANK: begin
                        bank_pointer <= wr_merged[3:0];
                    end
                    `JI_OFS_INDEX: begin
                        index_base <= wr_merged[11:0];
                    end
                    `JI_OFS_MEM_ADDR: begin
                        mem_addr <= wr_merged[11:0];
                    end
                    default: begin
                        mem_addr <= mem_addr;
                    end
                endcase
            end

            case (state)
                ST_EXEC: begin
                    phase <= phase + 2'b01;
                    case (phase)
                        PH_Q1: begin
                            is_jump  <= (ireg[15:8] == `JI_OP_JUMP1);
                            is_incr  <= (ireg[15:10] == `JI_OP_INCR);
                            eff_addr <= data_address(ireg[7:0], ireg[8],
                                ext_enable, bank_pointer, index_base);
                        end
                        PH_Q2: begin
                            jump_low <= ireg[7:0];
                            operand  <= data_mem[eff_addr];
                        end
                        PH_Q3: begin
                            result     <= alu_result;
                            next_flags <= {alu_n, alu_tcerr, alu_z,
                                           alu_nibble, alu_c};
                        end
                        PH_Q4: begin
                            if (is_jump) begin
                                // hold the last phase for the high literal
                                phase <= PH_Q4;
                                state <= ST_WORD2;
                            end else if (is_incr) begin
                                if (!ireg[9]) begin
                                    accumulator <= result;
                                end
                                flags <= next_flags;
                                program_counter <= program_counter +
                                                   `JI_PROG_STEP;
                                state <= ST_IDLE;
                            end else begin
                                if (!bad_opcode) begin
                                    bad_opcode <= 1'b1;
                                end
                                program_counter <= program_counter +
                                                   `JI_PROG_STEP;
                                state <= ST_IDLE;
                            end
                        end
                        default: begin
                            phase <= PH_Q1;
                        end
                    endcase
                end
                ST_WORD2: begin
                    if (wr_fire && instr_ofs) begin
                        if (instr_in[15:12] == `JI_OP_JUMP2) begin
                            // full 20-bit target, any program address
                            program_counter <= {instr_in[11:0], jump_low,
                                                1'b0};
                        end else begin
                            bad_word2 <= 1'b1;
                        end
                        phase <= PH_Q1;
                        state <= ST_NOP;
                    end
                end
                ST_NOP: begin
                    // second cycle of the jump does nothing
                    phase <= phase + 2'b01;
                    if (phase == PH_Q4) begin
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    phase <= PH_Q1;
                end
            endcase
        end
    end

endmodule

`default_nettype wire

// ### hdl/jump_incr_map.vh
`ifndef JUMP_INCR_MAP_VH
`define JUMP_INCR_MAP_VH

// ****************************************
// register byte offsets
// ****************************************
`define JI_OFS_INSTR      6'h00
`define JI_OFS_CTRL       6'h04
`define JI_OFS_STATUS     6'h08
`define JI_OFS_PROG       6'h0c
`define JI_OFS_ACC        6'h10
`define JI_OFS_BANK       6'h14
`define JI_OFS_INDEX      6'h18
`define JI_OFS_MEM_ADDR   6'h1c
`define JI_OFS_MEM_DATA   6'h20

// ****************************************
// field positions
// ****************************************
`define JI_CTRL_EXT_BIT   0
`define JI_FLAG_C_BIT     0
`define JI_FLAG_NB_BIT    1
`define JI_FLAG_Z_BIT     2
`define JI_FLAG_TE_BIT    3
`define JI_FLAG_N_BIT     4
`define JI_ST_BUSY_BIT    8
`define JI_ST_WORD2_BIT   9
`define JI_ST_BADW2_BIT   10
`define JI_ST_BADOP_BIT   11

// ****************************************
// opcodes and addressing
// ****************************************
`define JI_OP_JUMP1       8'hef
`define JI_OP_JUMP2       4'hf
`define JI_OP_INCR        6'h0a
`define JI_IDX_LIMIT      8'h5f
`define JI_ACCESS_SPLIT   8'h60
`define JI_ACCESS_LOW     4'h0
`define JI_ACCESS_HIGH    4'hf
`define JI_PROG_STEP      21'h000002

// ****************************************
// reset values
// ****************************************
`define JI_RST_PROG       21'h000000
`define JI_RST_BYTE       8'h00
`define JI_RST_BANK       4'h0
`define JI_RST_ADDR       12'h000
`define JI_RST_FLAGS      5'h00

`endif

// ### tb/jump_and_increment_exec_props.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// bus and sequencing checks
// ****************************************
module jump_and_increment_exec_props (
    input wire logic        clk_sys_i,
    input wire logic        rst_b_i,
    input wire logic [5:0]  avs_address_i,
    input wire logic        avs_read_i,
    input wire logic        avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0]  avs_byteenable_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic        avs_waitrequest_o
);
    logic [2:0] busy_left;
    logic       pend_jump;
    logic       wait_word2;
    wire        rd_take;
    wire        instr_take;

    assign rd_take    = avs_read_i && !avs_waitrequest_o;
    assign instr_take = avs_write_i && !avs_waitrequest_o
                        && avs_address_i == 6'h00;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);

    // shadow of the four-phase sequencer, seen from the bus
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            busy_left  <= 3'd0;
            pend_jump  <= 1'b0;
            wait_word2 <= 1'b0;
        end else if (instr_take && wait_word2) begin
            wait_word2 <= 1'b0;
            busy_left  <= 3'd4;
        end else if (instr_take && busy_left == 3'd0) begin
            busy_left <= 3'd4;
            pend_jump <= avs_writedata_i[15:8] == 8'hef;
        end else if (busy_left != 3'd0) begin
            busy_left <= busy_left - 3'd1;
            if (busy_left == 3'd1 && pend_jump) begin
                wait_word2 <= 1'b1;
                pend_jump  <= 1'b0;
            end
        end
    end

    chk_idle_write: assert property (
        avs_write_i && busy_left == 3'd0 && !wait_word2
        |-> !avs_waitrequest_o) else $error("idle write stalled");
    chk_incr_stall: assert property (
        instr_take && !wait_word2 && avs_writedata_i[15:10] == 6'h0a
        |=> (!avs_write_i || avs_waitrequest_o)[*4]
        ##1 (!avs_write_i || !avs_waitrequest_o))
        else $error("increment not four cycles");
    chk_word2_taken: assert property (
        avs_write_i && wait_word2 && avs_address_i == 6'h00
        |-> !avs_waitrequest_o) else $error("second word stalled");
    chk_prog_even: assert property (
        rd_take && avs_address_i == 6'h0c |-> avs_readdata_o[0] == 1'b0)
        else $error("program counter bit0 set");
    chk_prog_range: assert property (
        rd_take && avs_address_i == 6'h0c
        |-> avs_readdata_o[31:21] == 11'h000)
        else $error("counter too wide");
    chk_instr_reads: assert property (
        rd_take && avs_address_i == 6'h00 |-> avs_readdata_o == 32'h0)
        else $error("program word readable");
    chk_acc_width: assert property (
        rd_take && avs_address_i == 6'h10
        |-> avs_readdata_o[31:8] == 24'h0) else $error("acc too wide");
    chk_bank_width: assert property (
        rd_take && avs_address_i == 6'h14
        |-> avs_readdata_o[31:4] == 28'h0) else $error("bank too wide");
    chk_index_width: assert property (
        rd_take && avs_address_i == 6'h18
        |-> avs_readdata_o[31:12] == 20'h0) else $error("index too wide");
endmodule

bind jump_and_increment_exec jump_and_increment_exec_props props_inst (
    .clk_sys_i         (clk_sys_i),
    .rst_b_i           (rst_b_i),
    .avs_address_i     (avs_address_i),
    .avs_read_i        (avs_read_i),
    .avs_write_i       (avs_write_i),
    .avs_writedata_i   (avs_writedata_i),
    .avs_byteenable_i  (avs_byteenable_i),
    .avs_readdata_o    (avs_readdata_o),
    .avs_waitrequest_o (avs_waitrequest_o)
);

`default_nettype wire

// ### tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// self-checking bench
// ****************************************
module testbench;
    logic        clk_sys_i;
    logic        rst_b_i;
    logic [5:0]  avs_address_i;
    logic        avs_read_i;
    logic        avs_write_i;
    logic [31:0] avs_writedata_i;
    logic [3:0]  avs_byteenable_i;
    logic [31:0] avs_readdata_o;
    logic        avs_waitrequest_o;
    int          bad_count;
    int          total_checks;

    jump_and_increment_exec jump_and_increment_exec_inst (
        .clk_sys_i         (clk_sys_i),
        .rst_b_i           (rst_b_i),
        .avs_address_i     (avs_address_i),
        .avs_read_i        (avs_read_i),
        .avs_write_i       (avs_write_i),
        .avs_writedata_i   (avs_writedata_i),
        .avs_byteenable_i  (avs_byteenable_i),
        .avs_readdata_o    (avs_readdata_o),
        .avs_waitrequest_o (avs_waitrequest_o)
    );

    always #5 clk_sys_i = ~clk_sys_i;

    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp,
                         input string what);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // one bus transfer; held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [5:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_sys_i);
        avs_address_i   <= a;
        avs_writedata_i <= d;
        avs_write_i     <= wr;
        avs_read_i      <= !wr;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 200);
        q = avs_readdata_o;
        check({31'h0, avs_waitrequest_o}, 32'h0, "bus answer");
        avs_write_i <= 1'b0;
        avs_read_i  <= 1'b0;
    endtask

    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [5:0] a, input logic [31:0] exp,
                      input string what);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check(q, exp, what);
    endtask

    task automatic test_reset();
        for (int i = 0; i < 8; i++) begin
            rd(6'(i * 4), 32'h0, "reset value");
        end
        wr(6'h24, 32'hffffffff);
        rd(6'h24, 32'h0, "unmapped offset");
        $display("test_reset done");
    endtask

    // jump with flags preset; second word accepted once waiting
    task automatic test_jump(input logic [15:0] w1, input logic [15:0] w2,
                             input logic [20:0] old_pc,
                             input logic [31:0] exp_st);
        logic [31:0] st;
        logic [20:0] exp_pc;
        exp_pc = (w2[15:12] == 4'hf) ? {w2[11:0], w1[7:0], 1'b0} : old_pc;
        wr(6'h08, 32'h15);
        wr(6'h00, {16'h0, w1});
        st = 32'h0;
        for (int i = 0; i < 8 && st[9] !== 1'b1; i++) begin
            bus(1'b0, 6'h08, 32'h0, st);
        end
        check(st & 32'h21f, 32'h215, "waiting for word2");
        wr(6'h00, {16'h0, w2});
        wr(6'h3c, 32'h0);
        rd(6'h0c, {11'h0, exp_pc}, "jump target");
        rd(6'h08, exp_st, "status after jump");
        $display("test_jump done");
    endtask

    task automatic test_incr(input logic [15:0] op, input logic [11:0] ma,
                             input logic [7:0] mv, input logic [7:0] exp_m,
                             input logic [7:0] exp_a, input logic [4:0] fl);
        wr(6'h0c, 32'h100);
        wr(6'h10, 32'h5a);
        wr(6'h1c, {20'h0, ma});
        wr(6'h20, {24'h0, mv});
        wr(6'h08, 32'h0);
        wr(6'h00, {16'h0, op});
        wr(6'h3c, 32'h0);
        rd(6'h20, {24'h0, exp_m}, "register after");
        rd(6'h10, {24'h0, exp_a}, "accumulator");
        rd(6'h08, {27'h0, fl}, "flags");
        rd(6'h0c, 32'h102, "counter step");
        $display("test_incr done");
    endtask

    // unknown opcode runs as a no-op and raises its sticky flag
    task automatic test_badop();
        wr(6'h0c, 32'h200);
        wr(6'h00, 32'h0000ffff);
        wr(6'h3c, 32'h0);
        rd(6'h08, 32'h800, "unknown opcode flag");
        rd(6'h0c, 32'h202, "counter after no-op");
        wr(6'h08, 32'h800);
        rd(6'h08, 32'h0, "opcode flag cleared");
        $display("test_badop done");
    endtask

    initial begin
        clk_sys_i        = 1'b0;
        rst_b_i          = 1'b0;
        avs_address_i    = 6'h00;
        avs_read_i       = 1'b0;
        avs_write_i      = 1'b0;
        avs_writedata_i  = 32'h0;
        avs_byteenable_i = 4'hf;
        bad_count        = 0;
        total_checks     = 0;
        repeat (6) @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        test_reset();
        test_jump(16'hef34, 16'hf123, 21'h0, 32'h15);
        test_jump(16'hefff, 16'hffff, 21'h0, 32'h15);
        test_jump(16'hef00, 16'he123, 21'h1ffffe, 32'h415);
        wr(6'h08, 32'h415);
        rd(6'h08, 32'h15, "sticky cleared");
        wr(6'h14, 32'h3);
        test_incr(16'h2b45, 12'h345, 8'h7f, 8'h80, 8'h5a, 5'h1a);
        test_incr(16'h2870, 12'hf70, 8'hff, 8'hff, 8'h00, 5'h07);
        test_incr(16'h2a10, 12'h010, 8'h41, 8'h42, 8'h5a, 5'h00);
        wr(6'h04, 32'h1);
        wr(6'h18, 32'h200);
        test_incr(16'h2a5f, 12'h25f, 8'h0f, 8'h10, 8'h5a, 5'h02);
        test_incr(16'h2a60, 12'hf60, 8'h00, 8'h01, 8'h5a, 5'h00);
        test_badop();
        results();
    end

    // hang guard
    initial begin
        repeat (5000) @(posedge clk_sys_i);
        bad_count++;
        $display("[FAIL] %0t watchdog expired", $time);
        results();
    end
endmodule

`default_nettype wire
